// File: design/aimc_top.sv
// Purpose: High-pass, peak hold, range and limit monitor for two input channels
// Assumes: Samples arrive from logic on clk_in, one valid pulse for both channels
// Notes: Command object and settings reached over Avalon-MM with waitrequest
//
// Local design decisions: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "aimc_consts.svh"

// What this block does
// - Second filter per channel: off by default, or high-pass 10 to 0.001 Hz.
// - High-pass is first-order recursive, rising twenty decibels per decade.
// - DC step or switching the high-pass on settles by cut-off dependent time.
// - Track most positive and most negative processed value, both readable.
// - Peaks clear on interface change, reset, control bit rise, peak request.
// - Low nibble of per-channel request picks channel: zero first, one second.
// - All-counters request clears peaks, range counters and limit counters everywhere.
// - Command status reads 255 while executing and 0 once done.
// - Unknown request code is refused with abort code 0x06040043.
// - Over and underrange bits against nominal scale, no settings, no clamping.
// - Error thresholds set error bit, LED, and count under or over events.
// - Default thresholds are the technical full-scale ends of the interface.
// - Legacy integer range uses fixed 32767 and -32768, writes ignored.
// - Interface or scaling change restores thresholds to interface defaults.
// - Range-error state returns to default on interface change, reset, request.
// - Two independent limit comparators, own enable off by default, own value.
// - Limit code: 0 disabled, 1 below, 2 above, 3 equal.
// - Low and high counters count transitions to below and to above limit.
// - Limit counters clear on interface change, reset, or limit request.
// - Swap setting exchanges limit codes 1 and 2, keeps 0 and 3.
module aimc_top
    import aimc_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Avalon-MM slave
    input wire aimc_avs_s avs_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // Samples and control word bits
    input wire logic sample_valid_in,
    input wire logic [1:0][15:0] sample_in,
    input wire logic [1:0] peak_reset_in,
    // Results
    output logic [1:0][15:0] value_out,
    output logic [1:0] value_valid_out,
    output var aimc_stat_s [1:0] status_out,
    output logic error_led_out,
    output logic cmd_busy_out
);

    aimc_state_s s;
    aimc_state_s next;

    function automatic logic aimc_bipolar(input logic [2:0] iface);
        aimc_bipolar = (iface == `AIMC_IF_V_BIPOLAR) || (iface == `AIMC_IF_I_BIPOLAR);
    endfunction : aimc_bipolar

    function automatic logic [15:0] aimc_thr_lo_def(input logic [2:0] iface);
        aimc_thr_lo_def = aimc_bipolar(iface) ? `AIMC_FS_TECH_LO : 16'h0000;
    endfunction : aimc_thr_lo_def

    // Zero shift means the filter is off
    function automatic logic [4:0] aimc_hp_shift(input logic [2:0] sel);
        unique case (sel)
            3'h1: aimc_hp_shift = `AIMC_HP_SHIFT_10HZ;
            3'h2: aimc_hp_shift = `AIMC_HP_SHIFT_1HZ;
            3'h3: aimc_hp_shift = `AIMC_HP_SHIFT_100MHZ;
            3'h4: aimc_hp_shift = `AIMC_HP_SHIFT_10MHZ;
            3'h5: aimc_hp_shift = `AIMC_HP_SHIFT_1MHZ;
            default: aimc_hp_shift = 5'h00;
        endcase
    endfunction : aimc_hp_shift

    function automatic logic [15:0] aimc_be(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        aimc_be = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction : aimc_be

    function automatic logic [31:0] aimc_rd(input aimc_state_s st, input logic [7:0] a);
        aimc_chan_s c;
        c = st.ch[a[7]];
        aimc_rd = 32'h0000_0000;
        if (a == `AIMC_OFS_CMD_REQ) begin
            aimc_rd = {16'h0000, st.req};
        end else if (a == `AIMC_OFS_CMD_STAT) begin
            aimc_rd = {24'h00_0000, st.cmd_stat};
        end else if (a == `AIMC_OFS_CMD_ABORT) begin
            aimc_rd = st.abort;
        end else if (a[7] ^ a[6]) begin
            unique case (a[5:0])
                `AIMC_OFS_CFG: aimc_rd = {22'h00_0000, c.cfg};
                `AIMC_OFS_THR_LO: aimc_rd = {16'h0000, c.low_error_threshold};
                `AIMC_OFS_THR_HI: aimc_rd = {16'h0000, c.high_error_threshold};
                `AIMC_OFS_LIM1: aimc_rd = {16'h0000, c.lim_val[0]};
                `AIMC_OFS_LIM2: aimc_rd = {16'h0000, c.lim_val[1]};
                `AIMC_OFS_PK_POS: aimc_rd = {16'h0000, c.pk_pos};
                `AIMC_OFS_PK_NEG: aimc_rd = {16'h0000, c.pk_neg};
                `AIMC_OFS_CNT_UNDER: aimc_rd = {16'h0000, c.cnt_under};
                `AIMC_OFS_CNT_OVER: aimc_rd = {16'h0000, c.cnt_over};
                `AIMC_OFS_L1_LO: aimc_rd = {16'h0000, c.cnt_lo[0]};
                `AIMC_OFS_L1_HI: aimc_rd = {16'h0000, c.cnt_hi[0]};
                `AIMC_OFS_L2_LO: aimc_rd = {16'h0000, c.cnt_lo[1]};
                `AIMC_OFS_L2_HI: aimc_rd = {16'h0000, c.cnt_hi[1]};
                `AIMC_OFS_VALUE: aimc_rd = {16'h0000, c.value};
                default: aimc_rd = 32'h0000_0000;
            endcase
        end
    endfunction : aimc_rd

    always_comb begin
        logic req_any;
        logic cmd_wr;
        logic done;
        logic req_ok;
        logic [1:0] clr_pk;
        logic [1:0] clr_re;
        logic [1:0] clr_lim;
        logic [1:0] thr_def;
        logic [1:0] ch_hit;
        aimc_cfg_s wcfg;
        logic [4:0] k;
        logic [39:0] xs;
        logic signed [40:0] diff;
        logic signed [40:0] step;
        logic signed [16:0] y;
        logic [15:0] v;
        logic [15:0] lo_eff;
        logic [15:0] hi_eff;
        logic [15:0] nom;
        logic e_lo;
        logic e_hi;
        logic [1:0] rel;
        logic [1:0] code;
        req_any = 1'b0;
        cmd_wr = 1'b0;
        done = 1'b0;
        req_ok = 1'b0;
        clr_pk = 2'h0;
        clr_re = 2'h0;
        clr_lim = 2'h0;
        thr_def = 2'h0;
        ch_hit = 2'h0;
        wcfg = '0;
        k = 5'h00;
        xs = 40'h00_0000_0000;
        diff = '0;
        step = '0;
        y = '0;
        v = 16'h0000;
        lo_eff = 16'h0000;
        hi_eff = 16'h0000;
        nom = 16'h0000;
        e_lo = 1'b0;
        e_hi = 1'b0;
        rel = 2'h0;
        code = 2'h0;
        next = s;

        // Bus: accept lowers waitrequest for one cycle, effect at that edge
        req_any = avs_in.read | avs_in.write;
        cmd_wr = avs_in.write && (avs_in.address == `AIMC_OFS_CMD_REQ);
        done = req_any & ~s.waitreq;
        next.waitreq = 1'b1;
        if (req_any && s.waitreq && !(cmd_wr && s.cmd != AIMC_IDLE)) begin
            next.waitreq = 1'b0;
            next.rdata = avs_in.read ? aimc_rd(s, avs_in.address) : 32'h0000_0000;
        end

        unique case (s.cmd)
            AIMC_IDLE: begin
                if (done && cmd_wr) begin
                    next.req = aimc_be(s.req, avs_in.writedata, avs_in.byteenable);
                    next.cmd = AIMC_EXEC;
                    next.cmd_stat = `AIMC_STAT_BUSY;
                    next.abort = 32'h0000_0000;
                end
            end
            AIMC_EXEC: begin
                next.cmd = AIMC_IDLE;
                next.cmd_stat = `AIMC_STAT_DONE;
                ch_hit = (s.req[3:0] == 4'h0) ? 2'b01 : (s.req[3:0] == 4'h1) ? 2'b10 : 2'b00;
                if (s.req == `AIMC_REQ_ALL) begin
                    req_ok = 1'b1;
                    clr_pk = 2'b11;
                    clr_re = 2'b11;
                    clr_lim = 2'b11;
                end else if (ch_hit != 2'b00) begin
                    req_ok = 1'b1;
                    if (s.req[15:4] == `AIMC_REQ_PEAK) begin
                        clr_pk = ch_hit;
                    end else if (s.req[15:4] == `AIMC_REQ_RERR) begin
                        clr_re = ch_hit;
                    end else if (s.req[15:4] == `AIMC_REQ_LIM) begin
                        clr_lim = ch_hit;
                    end else begin
                        req_ok = 1'b0;
                    end
                end
                if (!req_ok) begin
                    next.abort = `AIMC_ABORT_INCOMPAT;
                end
            end
        endcase

        // Channel settings writes
        if (done && avs_in.write && (avs_in.address[7] ^ avs_in.address[6])) begin
            unique case (avs_in.address[5:0])
                `AIMC_OFS_CFG: begin
                    wcfg = aimc_cfg_s'(10'(aimc_be({6'h00, s.ch[avs_in.address[7]].cfg},
                                                   avs_in.writedata, avs_in.byteenable)));
                    next.ch[avs_in.address[7]].cfg = wcfg;
                    if (wcfg.iface != s.ch[avs_in.address[7]].cfg.iface) begin
                        clr_pk[avs_in.address[7]] = 1'b1;
                        clr_re[avs_in.address[7]] = 1'b1;
                        clr_lim[avs_in.address[7]] = 1'b1;
                    end
                    if (wcfg.integer_range_scaling !=
                        s.ch[avs_in.address[7]].cfg.integer_range_scaling) begin
                        thr_def[avs_in.address[7]] = 1'b1;
                    end
                end
                `AIMC_OFS_THR_LO: begin
                    if (!s.ch[avs_in.address[7]].cfg.integer_range_scaling) begin
                        next.ch[avs_in.address[7]].low_error_threshold = aimc_be(
                            s.ch[avs_in.address[7]].low_error_threshold,
                            avs_in.writedata, avs_in.byteenable);
                    end
                end
                `AIMC_OFS_THR_HI: begin
                    if (!s.ch[avs_in.address[7]].cfg.integer_range_scaling) begin
                        next.ch[avs_in.address[7]].high_error_threshold = aimc_be(
                            s.ch[avs_in.address[7]].high_error_threshold,
                            avs_in.writedata, avs_in.byteenable);
                    end
                end
                `AIMC_OFS_LIM1: begin
                    next.ch[avs_in.address[7]].lim_val[0] = aimc_be(
                        s.ch[avs_in.address[7]].lim_val[0], avs_in.writedata, avs_in.byteenable);
                end
                `AIMC_OFS_LIM2: begin
                    next.ch[avs_in.address[7]].lim_val[1] = aimc_be(
                        s.ch[avs_in.address[7]].lim_val[1], avs_in.writedata, avs_in.byteenable);
                end
                default: begin
                end
            endcase
        end

        for (int i = 0; i < 2; i++) begin
            next.ch[i].pr_prev = peak_reset_in[i];
            if (peak_reset_in[i] && !s.ch[i].pr_prev) begin
                clr_pk[i] = 1'b1;
            end
            next.ch[i].valid = 1'b0;

            if (sample_valid_in) begin
                next.ch[i].valid = 1'b1;
                k = aimc_hp_shift(s.ch[i].cfg.hp_sel);
                if (k == 5'h00) begin
                    // Off clears the estimate so switching on settles
                    next.ch[i].value = sample_in[i];
                    next.ch[i].acc = 40'h00_0000_0000;
                end else begin
                    xs = {sample_in[i], 24'h00_0000};
                    diff = $signed({xs[39], xs}) - $signed({s.ch[i].acc[39], s.ch[i].acc});
                    step = diff >>> k;
                    next.ch[i].acc = s.ch[i].acc + step[39:0];
                    y = $signed({sample_in[i][15], sample_in[i]}) -
                        $signed({s.ch[i].acc[39], s.ch[i].acc[39:24]});
                    if (y[16] != y[15]) begin
                        next.ch[i].value = y[16] ? 16'h8000 : 16'h7FFF;
                    end else begin
                        next.ch[i].value = y[15:0];
                    end
                end
            end

            if (s.ch[i].valid) begin
                v = s.ch[i].value;
                if (s.ch[i].pk_rearm) begin
                    next.ch[i].pk_pos = v;
                    next.ch[i].pk_neg = v;
                    next.ch[i].pk_rearm = 1'b0;
                end else begin
                    if ($signed(v) > $signed(s.ch[i].pk_pos)) begin
                        next.ch[i].pk_pos = v;
                    end
                    if ($signed(v) < $signed(s.ch[i].pk_neg)) begin
                        next.ch[i].pk_neg = v;
                    end
                end

                nom = s.ch[i].cfg.integer_range_scaling ? `AIMC_FS_NOM_LEG : `AIMC_FS_NOM_EXT;
                next.ch[i].stat.overrange = $signed(v) > $signed(nom);
                next.ch[i].stat.underrange = aimc_bipolar(s.ch[i].cfg.iface) ?
                    ($signed(v) < -$signed(nom)) : v[15];

                lo_eff = s.ch[i].cfg.integer_range_scaling ? `AIMC_FS_TECH_LO :
                         s.ch[i].low_error_threshold;
                hi_eff = s.ch[i].cfg.integer_range_scaling ? `AIMC_FS_TECH_HI :
                         s.ch[i].high_error_threshold;
                e_lo = $signed(v) < $signed(lo_eff);
                e_hi = $signed(v) > $signed(hi_eff);
                next.ch[i].stat.error = e_lo | e_hi;
                next.ch[i].err_lo_prev = e_lo;
                next.ch[i].err_hi_prev = e_hi;
                if (e_lo && !s.ch[i].err_lo_prev) begin
                    next.ch[i].cnt_under = s.ch[i].cnt_under + 16'h0001;
                end
                if (e_hi && !s.ch[i].err_hi_prev) begin
                    next.ch[i].cnt_over = s.ch[i].cnt_over + 16'h0001;
                end

                for (int j = 0; j < 2; j++) begin
                    if (!s.ch[i].cfg.lim_en[j]) begin
                        rel = 2'h0;
                    end else if ($signed(v) < $signed(s.ch[i].lim_val[j])) begin
                        rel = 2'h1;
                    end else if ($signed(v) > $signed(s.ch[i].lim_val[j])) begin
                        rel = 2'h2;
                    end else begin
                        rel = 2'h3;
                    end
                    code = (s.ch[i].cfg.limit_code_swap && (rel[0] ^ rel[1])) ? ~rel : rel;
                    if (j == 0) begin
                        next.ch[i].stat.limit1 = code;
                    end else begin
                        next.ch[i].stat.limit2 = code;
                    end
                    if (rel == 2'h1 && s.ch[i].rel_prev[j] != 2'h1) begin
                        next.ch[i].cnt_lo[j] = s.ch[i].cnt_lo[j] + 16'h0001;
                    end
                    if (rel == 2'h2 && s.ch[i].rel_prev[j] != 2'h2) begin
                        next.ch[i].cnt_hi[j] = s.ch[i].cnt_hi[j] + 16'h0001;
                    end
                    next.ch[i].rel_prev[j] = rel;
                end
            end

            if (clr_pk[i]) begin
                next.ch[i].pk_pos = 16'h0000;
                next.ch[i].pk_neg = 16'h0000;
                next.ch[i].pk_rearm = 1'b1;
            end
            if (clr_re[i]) begin
                next.ch[i].cnt_under = 16'h0000;
                next.ch[i].cnt_over = 16'h0000;
                thr_def[i] = 1'b1;
            end
            if (thr_def[i]) begin
                next.ch[i].low_error_threshold = aimc_thr_lo_def(next.ch[i].cfg.iface);
                next.ch[i].high_error_threshold = `AIMC_FS_TECH_HI;
            end
            if (clr_lim[i]) begin
                next.ch[i].cnt_lo = '0;
                next.ch[i].cnt_hi = '0;
            end
        end

        next.led = next.ch[0].stat.error | next.ch[1].stat.error;
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s <= '0;
            s.cmd <= AIMC_IDLE;
            s.cmd_stat <= `AIMC_STAT_DONE;
            s.waitreq <= 1'b1;
            for (int i = 0; i < 2; i++) begin
                s.ch[i].cfg <= aimc_cfg_s'(`AIMC_CFG_RST);
                s.ch[i].low_error_threshold <= `AIMC_FS_TECH_LO;
                s.ch[i].high_error_threshold <= `AIMC_FS_TECH_HI;
                s.ch[i].pk_rearm <= 1'b1;
            end
        end else begin
            s <= next;
        end
    end

    assign avs_readdata_out = s.rdata;
    assign avs_waitrequest_out = s.waitreq;
    assign error_led_out = s.led;
    assign cmd_busy_out = s.cmd[1];

    generate
        for (genvar g = 0; g < 2; g++) begin : g_out
            assign value_out[g] = s.ch[g].value;
            assign value_valid_out[g] = s.ch[g].valid;
            assign status_out[g] = s.ch[g].stat;
        end
    endgenerate

endmodule : aimc_top
`default_nettype wire

// File: design/aimc_consts.svh
// Purpose: Offsets, codes, reset values and limits of the input monitor chain
// Assumes: Byte addresses on a 32-bit Avalon-MM slave
// Notes: Channel n registers sit at AIMC_CH_BASE * (n + 1)
`ifndef AIMC_CONSTS_SVH
`define AIMC_CONSTS_SVH

`define AIMC_OFS_CMD_REQ 8'h00
`define AIMC_OFS_CMD_STAT 8'h04
`define AIMC_OFS_CMD_ABORT 8'h08
`define AIMC_CH_BASE 8'h40
`define AIMC_OFS_CFG 6'h00
`define AIMC_OFS_THR_LO 6'h04
`define AIMC_OFS_THR_HI 6'h08
`define AIMC_OFS_LIM1 6'h0C
`define AIMC_OFS_LIM2 6'h10
`define AIMC_OFS_PK_POS 6'h14
`define AIMC_OFS_PK_NEG 6'h18
`define AIMC_OFS_CNT_UNDER 6'h1C
`define AIMC_OFS_CNT_OVER 6'h20
`define AIMC_OFS_L1_LO 6'h24
`define AIMC_OFS_L1_HI 6'h28
`define AIMC_OFS_L2_LO 6'h2C
`define AIMC_OFS_L2_HI 6'h30
`define AIMC_OFS_VALUE 6'h34

// Config word: [2:0] hp, [5:3] iface, [6] scaling, [7] swap, [9:8] limit enables
`define AIMC_CFG_RST 10'h008

`define AIMC_REQ_ALL 16'h3001
`define AIMC_REQ_PEAK 12'h301
`define AIMC_REQ_RERR 12'h302
`define AIMC_REQ_LIM 12'h303
`define AIMC_STAT_BUSY 8'hFF
`define AIMC_STAT_DONE 8'h00
`define AIMC_ABORT_INCOMPAT 32'h06040043

`define AIMC_HP_SHIFT_10HZ 5'h05
`define AIMC_HP_SHIFT_1HZ 5'h08
`define AIMC_HP_SHIFT_100MHZ 5'h0B
`define AIMC_HP_SHIFT_10MHZ 5'h0F
`define AIMC_HP_SHIFT_1MHZ 5'h12

`define AIMC_IF_V_BIPOLAR 3'h1
`define AIMC_IF_I_BIPOLAR 3'h3
`define AIMC_FS_TECH_HI 16'h7FFF
`define AIMC_FS_TECH_LO 16'h8000
`define AIMC_FS_NOM_EXT 16'h7736
`define AIMC_FS_NOM_LEG 16'h7FFF

`endif

// File: design/aimc_pkg.sv
// Purpose: Types of the input monitor chain
// Assumes: Two channels, 16-bit signed samples
// Notes: Whole block state is one packed struct
package aimc_pkg;
    typedef enum logic [1:0] {AIMC_IDLE = 2'b01, AIMC_EXEC = 2'b10} aimc_cmd_e;
    typedef logic [15:0] aimc_word_t;
    typedef struct packed {
        logic read;
        logic write;
        logic [7:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } aimc_avs_s;
    typedef struct packed {
        logic [1:0] lim_en;
        logic limit_code_swap;
        logic integer_range_scaling;
        logic [2:0] iface;
        logic [2:0] hp_sel;
    } aimc_cfg_s;
    typedef struct packed {
        logic underrange;
        logic overrange;
        logic [1:0] limit1;
        logic [1:0] limit2;
        logic error;
    } aimc_stat_s;
    typedef struct packed {
        aimc_cfg_s cfg;
        aimc_word_t low_error_threshold;
        aimc_word_t high_error_threshold;
        logic [1:0][15:0] lim_val;
        logic [39:0] acc;
        aimc_word_t value;
        logic valid;
        aimc_word_t pk_pos;
        aimc_word_t pk_neg;
        logic pk_rearm;
        aimc_word_t cnt_under;
        aimc_word_t cnt_over;
        logic [1:0][15:0] cnt_lo;
        logic [1:0][15:0] cnt_hi;
        logic err_lo_prev;
        logic err_hi_prev;
        logic [1:0][1:0] rel_prev;
        aimc_stat_s stat;
        logic pr_prev;
    } aimc_chan_s;
    typedef struct packed {
        aimc_chan_s [1:0] ch;
        aimc_cmd_e cmd;
        logic [15:0] req;
        logic [7:0] cmd_stat;
        logic [31:0] abort;
        logic waitreq;
        logic [31:0] rdata;
        logic led;
    } aimc_state_s;
endpackage : aimc_pkg

// File: testbench/aimc_props.sv
// Purpose: Port assertions of the input monitor chain
// Assumes: One clock, async active-low reset
// Notes: Bound into aimc_top
`timescale 1ns/10ps
`default_nettype none
module aimc_props
    import aimc_pkg::*;
(
    input wire logic clk_in, reset_n_in, sample_valid_in,
    input wire aimc_avs_s avs_in,
    input wire logic avs_waitrequest_out, error_led_out, cmd_busy_out,
    input wire logic [1:0][15:0] value_out,
    input wire logic [1:0] value_valid_out,
    input wire aimc_stat_s [1:0] status_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    sequence s_busy_end; cmd_busy_out ##1 !cmd_busy_out; endsequence
    property p_vv; sample_valid_in |=> value_valid_out == 2'h3; endproperty
    a_vv: assert property (p_vv) else $error("value valid missing");
    property p_hold; !sample_valid_in |=> $stable(value_out); endproperty
    a_hold: assert property (p_hold) else $error("value moved without sample");
    property p_wr_one; !avs_waitrequest_out |=> avs_waitrequest_out; endproperty
    a_wr_one: assert property (p_wr_one) else $error("waitrequest low too long");
    property p_ans;
        avs_in.read && avs_waitrequest_out |-> ##[0:3] !avs_waitrequest_out; endproperty
    a_ans: assert property (p_ans) else $error("read not answered");
    property p_busy; $rose(cmd_busy_out) |-> s_busy_end; endproperty
    a_busy: assert property (p_busy) else $error("busy not one cycle");
    property p_busy_src; $rose(cmd_busy_out) |-> $past(avs_in.write); endproperty
    a_busy_src: assert property (p_busy_src) else $error("busy without write");
    property p_led; error_led_out == (status_out[0].error | status_out[1].error); endproperty
    a_led: assert property (p_led) else $error("led differs from error bits");
    property p_ovun; !(status_out[0].overrange && status_out[0].underrange); endproperty
    a_ovun: assert property (p_ovun) else $error("over and under together");
endmodule : aimc_props
bind aimc_top aimc_props i_aimc_props(.clk_in(clk_in), .reset_n_in(reset_n_in),
    .sample_valid_in(sample_valid_in), .avs_in(avs_in), .error_led_out(error_led_out),
    .avs_waitrequest_out(avs_waitrequest_out), .cmd_busy_out(cmd_busy_out),
    .value_out(value_out), .value_valid_out(value_valid_out), .status_out(status_out));
`default_nettype wire

// File: testbench/aimc_master.sv
// Purpose: Avalon-MM master standing in for the fieldbus master
// Assumes: Slave ends each transfer by waitrequest low
// Notes: Transfer task is called from tb_top
`timescale 1ns/10ps
`default_nettype none
module aimc_master
    import aimc_pkg::*;
(
    input wire logic clk_in,
    input wire logic waitrequest_in,
    input wire logic [31:0] readdata_in,
    output var aimc_avs_s avs_out
);
    initial avs_out = '0;
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
        @(posedge clk_in);
        avs_out <= '{read: !wr, write: wr, address: a, writedata: d, byteenable: 4'hF};
        do begin
            @(posedge clk_in);
        end while (waitrequest_in !== 1'b0);
        q = readdata_in;
        avs_out <= '0;
    endtask : xfer
endmodule : aimc_master
`default_nettype wire

// File: testbench/tb_top.sv
// Purpose: Self-checking bench of the input monitor chain
// Assumes: Interface never changed
// Notes: Random samples from an LFSR seeded at 24939
`timescale 1ns/10ps
`default_nettype none
`include "aimc_consts.svh"
module tb_top;
    import aimc_pkg::*;
    logic clk_in, reset_n_in, sample_valid_in, avs_waitrequest_out, error_led_out;
    logic [1:0][15:0] sample_in, value_out;
    logic [1:0] peak_reset_in, value_valid_out;
    logic [31:0] rd, avs_readdata_out;
    logic [15:0] lfsr, pmax, pmin;
    logic [15:0] lv [3] = '{16'h0020, 16'h0010, 16'hFFF0};
    aimc_avs_s avs_in;
    aimc_stat_s [1:0] status_out;
    int num_errors, n_compared;
    aimc_top i_aimc_top(.clk_in(clk_in), .reset_n_in(reset_n_in), .avs_in(avs_in),
        .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
        .sample_valid_in(sample_valid_in), .sample_in(sample_in), .peak_reset_in(peak_reset_in),
        .value_out(value_out), .value_valid_out(value_valid_out), .status_out(status_out),
        .error_led_out(error_led_out), .cmd_busy_out());
    aimc_master i_aimc_master(.clk_in(clk_in), .waitrequest_in(avs_waitrequest_out),
        .readdata_in(avs_readdata_out), .avs_out(avs_in));
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    function automatic logic [15:0] step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : step
    function automatic logic [1:0] lim_code(input logic [15:0] v, l, input logic sw);
        if (v == l) return 2'h3;
        return (($signed(v) < $signed(l)) ^ sw) ? 2'h1 : 2'h2;
    endfunction : lim_code
    task automatic check(input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        i_aimc_master.xfer(1'b0, a, 32'h0, rd);
        check(rd, exp);
    endtask : rc
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_aimc_master.xfer(1'b1, a, d, rd);
    endtask : wr
    task automatic smp(input logic [15:0] a, b);
        @(posedge clk_in);
        sample_valid_in <= 1'b1;
        sample_in <= {b, a};
        @(posedge clk_in);
        sample_valid_in <= 1'b0;
        repeat (2) @(posedge clk_in);
    endtask : smp
    task automatic wrap_up;
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up
    initial begin
        #100us;
        num_errors++;
        wrap_up();
    end
    initial begin
        reset_n_in = 1'b0;
        sample_valid_in = 1'b0;
        sample_in = '0;
        peak_reset_in = '0;
        lfsr = 16'd24939;
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1'b1;
        rc(`AIMC_CH_BASE + `AIMC_OFS_CFG, {22'h0, `AIMC_CFG_RST});
        rc(`AIMC_CH_BASE + `AIMC_OFS_THR_LO, 32'h8000);
        for (int i = 0; i < 8; i++) begin
            lfsr = step(lfsr);
            smp(lfsr, ~lfsr);
            check(value_out[0], lfsr);
            pmax = (i == 0 || $signed(lfsr) > $signed(pmax)) ? lfsr : pmax;
            pmin = (i == 0 || $signed(lfsr) < $signed(pmin)) ? lfsr : pmin;
        end
        rc(`AIMC_CH_BASE + `AIMC_OFS_PK_POS, pmax);
        rc(`AIMC_CH_BASE + `AIMC_OFS_PK_NEG, pmin);
        wr(`AIMC_OFS_CMD_REQ, 32'h3010);
        rc(`AIMC_OFS_CMD_STAT, 32'h0);
        rc(`AIMC_CH_BASE + `AIMC_OFS_PK_POS, 32'h0);
        rc(8'h80 + `AIMC_OFS_PK_POS, {16'h0, ~pmin});
        @(posedge clk_in);
        peak_reset_in <= 2'b10;
        rc(8'h80 + `AIMC_OFS_PK_NEG, 32'h0);
        wr(`AIMC_OFS_CMD_REQ, 32'h3050);
        rc(`AIMC_OFS_CMD_ABORT, `AIMC_ABORT_INCOMPAT);
        wr(`AIMC_CH_BASE + `AIMC_OFS_LIM1, 32'h0010);
        for (int j = 0; j < 6; j++) begin
            wr(`AIMC_CH_BASE + `AIMC_OFS_CFG, (j < 3) ? 32'h108 : 32'h188);
            smp(lv[j % 3], 16'h0);
            check(status_out[0].limit1, lim_code(lv[j % 3], 16'h0010, j >= 3));
        end
        rc(`AIMC_CH_BASE + `AIMC_OFS_L1_LO, 32'h2);
        rc(`AIMC_CH_BASE + `AIMC_OFS_L1_HI, 32'h2);
        wr(`AIMC_OFS_CMD_REQ, 32'h3030);
        rc(`AIMC_CH_BASE + `AIMC_OFS_L1_LO, 32'h0);
        wr(`AIMC_CH_BASE + `AIMC_OFS_THR_HI, 32'h0100);
        smp(16'h7800, 16'h8000);
        check(error_led_out, 1'b1);
        check(status_out[0].overrange, 1'b1);
        check(status_out[1].underrange, 1'b1);
        rc(`AIMC_CH_BASE + `AIMC_OFS_CNT_OVER, 32'h1);
        wr(`AIMC_OFS_CMD_REQ, 32'h3020);
        rc(`AIMC_CH_BASE + `AIMC_OFS_THR_HI, 32'h7FFF);
        wr(`AIMC_CH_BASE + `AIMC_OFS_CFG, 32'h009);
        smp(16'h1000, 16'h0);
        check(value_out[0], 16'h1000);
        repeat (250) smp(16'h1000, 16'h0);
        check(value_out[0] < 16'h0010, 1'b1);
        wr(`AIMC_CH_BASE + `AIMC_OFS_CFG, 32'h048);
        wr(`AIMC_CH_BASE + `AIMC_OFS_THR_HI, 32'h0100);
        rc(`AIMC_CH_BASE + `AIMC_OFS_THR_HI, 32'h7FFF);
        wr(`AIMC_OFS_CMD_REQ, 32'h3001);
        rc(8'h80 + `AIMC_OFS_PK_NEG, 32'h0);
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
